// *** rtl/cfg_src.sv ***
// serial bitstream source: streams a stored bitstream bit by bit to a target
// assumes the enable, select and bit clock pins arrive asynchronously and are synchronised here; reconfig_instr is not; open-drain and
// two-way pins are split into in/out/enable, the wire is resolved outside
`timescale 1ns/1ps
module cfg_src
  import cfg_src_pkg::*;
#(
  parameter int POR_COUNT = cfg_src_pkg::POR_CYCLES,
  parameter bit REPROG = 1'b1,
  parameter bit AUTO_RESTART = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable_in,
  output logic enable_oe,
  input wire logic chip_select_in,
  output logic cascade_select_out,
  output cfg_src_pkg::drive_t serial_data,
  input wire logic serial_bit_clock_in,
  output cfg_src_pkg::drive_t serial_bit_clock,
  input wire logic reconfig_instr,
  output logic reconfig_req_oe
);
  import cfg_src_pkg::*;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] en_sync, cs_sync, sck_sync;
  always_ff @(posedge clk) begin
    en_sync <= {en_sync[0], enable_in};
    cs_sync <= {cs_sync[0], chip_select_in};
    sck_sync <= {sck_sync[0], serial_bit_clock_in};
  end
  wire en_low = ~en_sync[1];
  wire cs_high = cs_sync[1];

  // --------------------------------------------------------------------------
  // state and counters
  // --------------------------------------------------------------------------
  cfg_state_t state, next_state;
  logic [31:0] por_cnt;
  logic [ADDR_W-1:0] addr;
  logic [1:0] div;
  logic [4:0] wait_cnt;
  logic sck;
  logic store [STORE_BITS];
  logic en_low_q;

  // store content is preset here to alternating bits: address i holds bit i[0]
  initial for (int i = 0; i < STORE_BITS; i++) store[i] = i[0];

  // oscillator runs only while sending, enabled and with the select input low
  wire osc_run = (state == ST_SEND) & ~en_low & ~cs_high;
  wire tick = osc_run & (div == 2'(BIT_DIV - 1));
  wire fall_tick = (state == ST_DONE_WAIT) & (div == 2'(BIT_DIV - 1));
  wire en_fall = en_low & ~en_low_q;
  wire is_last = (addr == LAST_ADDR);

  // --------------------------------------------------------------------------
  // two-entry buffer between store and data pin
  // --------------------------------------------------------------------------
  bit_word_t buf_q [2];
  logic [1:0] buf_cnt;
  logic rd_ptr;
  logic wr_ptr;
  logic fetched_last;
  logic shown;
  wire buf_in_ready = (buf_cnt != 2'h2);
  wire buf_in_valid = osc_run & ~fetched_last;
  wire buf_out_valid = (buf_cnt != 2'h0);
  wire buf_out_ready = tick;
  wire push = buf_in_valid & buf_in_ready;
  wire pop = buf_out_valid & buf_out_ready;
  bit_word_t head;
  logic data_q;
  logic sent_last;
  assign head = buf_q[rd_ptr];

  always_ff @(posedge clk) begin
    if (sys_rst | en_low) begin
      buf_cnt <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      addr <= ADDR_RST;
      fetched_last <= 1'b0;
      sent_last <= 1'b0;
      data_q <= 1'b0;
      shown <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wr_ptr] <= '{data: store[addr], last: is_last};
        wr_ptr <= ~wr_ptr;
        addr <= addr + 10'h001;
        fetched_last <= is_last;
      end
      if (pop) begin
        data_q <= head.data;
        sent_last <= head.last;
        rd_ptr <= ~rd_ptr;
        shown <= 1'b1;
      end
      buf_cnt <= buf_cnt + 2'(push) - 2'(pop);
    end
  end

  // --------------------------------------------------------------------------
  // serial clock divider
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst | en_low) begin
      div <= 2'h0;
      sck <= 1'b0;
      en_low_q <= 1'b1;
    end else begin
      en_low_q <= en_low;
      div <= (osc_run | state == ST_DONE_WAIT) ? div + 2'h1 : 2'h0;
      // no rising edge before the first bit stands, else the target takes a stale bit
      sck <= (osc_run | state == ST_DONE_WAIT) & div[1] & shown;
    end
  end

  // --------------------------------------------------------------------------
  // control state machine
  // --------------------------------------------------------------------------
  wire last_out = tick & sent_last & ~buf_out_valid;
  always_comb begin
    next_state = state;
    case (state)
      ST_POR: if (por_cnt >= 32'(POR_COUNT - 1)) next_state = ST_WAIT;
      ST_WAIT: if (!en_low) next_state = cs_high ? ST_SLAVE : ST_SEND;
      ST_SEND: begin
        if (cs_high) next_state = ST_ERROR;
        else if (last_out) next_state = ST_DONE_WAIT;
      end
      ST_DONE_WAIT: begin
        if (cs_high) next_state = ST_IDLE;
        else if (wait_cnt == 5'(DONE_WAIT_BITS)) next_state = ST_ERROR;
      end
      ST_IDLE: next_state = ST_IDLE;
      ST_ERROR: if (AUTO_RESTART && en_low) next_state = ST_WAIT;
      ST_SLAVE: next_state = ST_SLAVE;
      default: next_state = ST_POR;
    endcase
    if (en_fall && state != ST_POR && state != ST_ERROR) next_state = ST_WAIT;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_POR;
      por_cnt <= 32'h0;
      wait_cnt <= 5'h0;
    end else begin
      state <= next_state;
      por_cnt <= (state == ST_POR) ? por_cnt + 32'h1 : 32'h0;
      if (state != ST_DONE_WAIT) wait_cnt <= 5'h0;
      else if (fall_tick) wait_cnt <= wait_cnt + 5'h1;
    end
  end

  // --------------------------------------------------------------------------
  // pins
  // --------------------------------------------------------------------------
  // error holds the enable line low; a non-restarting source stays there
  assign enable_oe = (state == ST_POR) | (state == ST_ERROR);
  wire drive_data = (state == ST_SEND) & ~en_low & ~cs_high;
  wire idle_hi = (state == ST_IDLE) & REPROG;
  assign serial_data = '{o: drive_data ? data_q : 1'b1, oe: drive_data | idle_hi};
  wire master = (state == ST_SEND) | (state == ST_DONE_WAIT) | (state == ST_IDLE);
  assign serial_bit_clock = '{o: (state == ST_IDLE) ? 1'b0 : sck, oe: master};
  assign cascade_select_out = ~((state == ST_DONE_WAIT) | (state == ST_IDLE));
  assign reconfig_req_oe = reconfig_instr;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  chk_reset_floats_data: assert property (@(posedge clk) disable iff (sys_rst)
    en_low |-> !serial_data.oe || idle_hi) else $error("data driven while enable low");
  chk_por_holds_enable: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_POR |-> enable_oe) else $error("enable not held in power-on reset");
  chk_slave_floats: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_SLAVE |-> !serial_data.oe && !serial_bit_clock.oe) else $error("slave drives");
  chk_early_select_err: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_SEND && cs_high && !en_fall |=> state == ST_ERROR) else $error("no error");
  chk_cascade_after_last: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_SEND && next_state == ST_DONE_WAIT |=> !cascade_select_out && !serial_data.oe)
    else $error("cascade not passed on");
  chk_idle_clock_low: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_IDLE |-> serial_bit_clock.o == 1'b0 && serial_data.oe == REPROG)
    else $error("idle pins wrong");
  chk_done_timeout: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_DONE_WAIT && wait_cnt == 5'(DONE_WAIT_BITS) && !cs_high && !en_fall
    |=> enable_oe) else $error("missing done timeout");
  chk_reconfig_follow: assert property (@(posedge clk) disable iff (sys_rst)
    reconfig_instr |-> reconfig_req_oe) else $error("reconfigure not held");
  chk_one_bit_tick: assert property (@(posedge clk) disable iff (sys_rst)
    pop |=> !pop) else $error("two bits in a row");
endmodule

// *** rtl/cfg_src_pkg.sv ***
// constants and carrier types for the serial bitstream source
// assumes a 20 MHz system clock; the bitstream store lives inside the source
package cfg_src_pkg;
  localparam int CLK_HZ = 20000000;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int POR_MS = 200;
  localparam int POR_CYCLES = (CLK_HZ / 1000) * POR_MS;
  localparam int DONE_WAIT_BITS = 16;
  localparam int BIT_DIV = 4;
  // --------------------------------------------------------------------------
  // store layout
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int STORE_BITS = 1024;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 10'h3FF;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;

  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_WAIT = 3'b001,
    ST_SEND = 3'b010,
    ST_DONE_WAIT = 3'b011,
    ST_IDLE = 3'b100,
    ST_ERROR = 3'b101,
    ST_SLAVE = 3'b110
  } cfg_state_t;

  typedef struct packed {
    logic data;
    logic last;
  } bit_word_t;

  typedef struct packed {
    logic o;
    logic oe;
  } drive_t;
endpackage

// *** verification/cfg_target_model.sv ***
// target configuration controller model: resolves the enable line, counts bits
// assumes the source's pins arrive split into value and enable
`timescale 1ns/1ps
module cfg_target_model
  import cfg_src_pkg::*;
(
  input wire logic clk,
  input wire logic enable_oe,
  input wire logic status_pull,
  input wire cfg_src_pkg::drive_t serial_data,
  input wire cfg_src_pkg::drive_t serial_bit_clock,
  input wire logic [10:0] done_after,
  output logic enable_in,
  output logic chip_select_in,
  output logic [10:0] bits_rx,
  output logic [10:0] bad_bits
);
  // ----
  // wire and receiver
  // ----
  logic sck_q;
  // pull-up: either party pulling low wins
  assign enable_in = ~(enable_oe | status_pull);
  // done rises once enough bits arrived; a huge limit keeps it low
  assign chip_select_in = (bits_rx >= done_after);
  always_ff @(posedge clk) begin
    sck_q <= serial_bit_clock.o;
    if (!enable_in) begin
      bits_rx <= 11'h000;
      bad_bits <= 11'h000;
    end else if (serial_bit_clock.o && !sck_q && serial_data.oe) begin
      bits_rx <= bits_rx + 11'h001;
      if (serial_data.o !== bits_rx[0]) bad_bits <= bad_bits + 11'h001;
    end
  end
endmodule

// *** verification/tb_serial_bitstream_config_source.sv ***
// bench for the serial bitstream source against the target model
// assumes the design's store holds alternating bits from address 0
`timescale 1ns/1ps
module tb_serial_bitstream_config_source;
  import cfg_src_pkg::*;
  // ----
  // harness
  // ----
  localparam int POR_N = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic status_pull = 1'b0;
  logic reconfig_instr = 1'b0;
  logic [10:0] done_after = 11'h7FF;
  logic enable_oe, enable_in, chip_select_in, cascade_select_out, reconfig_req_oe;
  drive_t serial_data, serial_bit_clock;
  logic [10:0] bits_rx, bad_bits;
  int bad_count = 0;
  int samples_checked = 0;
  int i;
  always #25 clk = ~clk;
  cfg_src #(.POR_COUNT(POR_N)) DUT (.clk, .sys_rst, .enable_in, .enable_oe,
    .chip_select_in, .cascade_select_out, .serial_data,
    .serial_bit_clock_in(serial_bit_clock.o), .serial_bit_clock,
    .reconfig_instr, .reconfig_req_oe);
  cfg_target_model partner (.clk, .enable_oe, .status_pull, .serial_data,
    .serial_bit_clock, .done_after, .enable_in, .chip_select_in, .bits_rx,
    .bad_bits);
  task automatic ck(input logic [10:0] seen, input logic [10:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // a short low pulse on the enable line from the target side
  task automatic pulse();
    @(posedge clk) status_pull <= 1'b1;
    tick(6);
    ck(serial_data.oe, 1'b0);
    @(posedge clk) status_pull <= 1'b0;
    tick(8);
  endtask
  task automatic t_por();
    tick(4);
    @(posedge clk) sys_rst <= 1'b0;
    tick(2);
    ck(enable_oe, 1'b1);
    ck(serial_data.oe, 1'b0);
    for (i = 0; i < 60 && enable_oe; i++) tick(1);
    ck(i >= POR_N - 4 && i < 40, 1'b1);
    tick(8);
    ck({serial_data.oe, serial_bit_clock.oe}, 2'b11);
  endtask
  task automatic t_full();
    for (i = 0; i < 5000 && cascade_select_out; i++) tick(1);
    ck(bits_rx, 11'h400);
    ck(bad_bits, 11'h000);
    ck({serial_data.oe, cascade_select_out}, 2'b00);
    @(posedge clk) done_after <= 11'h000;
    tick(8);
    ck({serial_bit_clock.o, serial_data.o, serial_data.oe}, 3'b011);
    ck(enable_oe, 1'b0);
    pulse();
    tick(20);
    ck(serial_data.oe, 1'b0);
  endtask
  task automatic t_early();
    @(posedge clk) done_after <= 11'h7FF;
    pulse();
    for (i = 0; i < 200 && bits_rx < 11'h008; i++) tick(1);
    @(posedge clk) done_after <= 11'h000;
    for (i = 0; i < 20 && !enable_oe; i++) tick(1);
    ck(enable_oe, 1'b1);
  endtask
  task automatic t_timeout();
    @(posedge clk) done_after <= 11'h7FF;
    pulse();
    for (i = 0; i < 5000 && cascade_select_out; i++) tick(1);
    for (i = 0; i < 200 && !enable_oe; i++) tick(1);
    ck(i >= 60 && i <= 72, 1'b1);
    for (i = 0; i < 100 && !serial_data.oe; i++) tick(1);
    ck(serial_data.oe, 1'b1);
  endtask
  task automatic t_reconfig();
    @(posedge clk) reconfig_instr <= 1'b1;
    tick(1);
    ck(reconfig_req_oe, 1'b1);
    @(posedge clk) reconfig_instr <= 1'b0;
    tick(1);
    ck(reconfig_req_oe, 1'b0);
  endtask
  task automatic t_slave();
    @(posedge clk) sys_rst <= 1'b1;
    done_after <= 11'h000;
    tick(4);
    @(posedge clk) sys_rst <= 1'b0;
    tick(POR_N + 40);
    ck({serial_data.oe, serial_bit_clock.oe}, 2'b00);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    test_done();
  end
  initial begin
    t_por();
    t_full();
    t_early();
    t_timeout();
    t_reconfig();
    t_slave();
    test_done();
  end
endmodule
